// [sbd_board_decode.sv]
// monitor card bus decode, strobes, wait, jump and interrupt routing
`timescale 1ns/1ps
// Functional notes
// RQ1: address 15..12 selects one of sixteen 4K blocks, gated by bank enable.
// RQ2: address 11..10 split the chosen block into four 1K selects.
// RQ3: address 11 splits the chosen block into two 2K selects.
// RQ4: i/o block base defaults to 70 hex and is relocatable.
// RQ5: port pairs: serial 70/71, 72/73, cassette 74/75, user 78/79, switch 7A/7B.
// RQ6: ports 76 and 77 select the device-assignment parallel port.
// RQ7: default map puts masked rom at F000-F7FF, extension at F800-FBFF.
// RQ8: second and third sockets take 1K or 2K parts by decoder choice.
// RQ9: default map puts static ram at FC00-FFFF.
// RQ10: when enabled, lines 16..19 form the bank enable.
// RQ11: without extended lines the bank enable is held active, the default.
// RQ12: four interrupt sources, each routable to one of eight bus lines.
// RQ13: wait option inserts exactly one wait state per bus cycle.
// RQ14: optional memory-write strobe is write pulse without output status.
// RQ15: reset jump drives its opcode bytes on the first reads after reset.
// RQ16: i/o block uses address 7..4; bits 3 and 2 both high disable it.
// RQ17: memory decode only while no input or output cycle runs.
// RQ18: card select on any hit; data-in drive on select with read, or jump.
// RQ19: host data latched on every memory write or output cycle.
// RQ20: chip selects mutually exclusive and inactive during reset.
module sbd_board_decode (
	// clock and reset
	input  logic        clk,
	input  logic        rst,
	// apb slave
	input  logic [7:0]  paddr,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [31:0] pwdata,
	input  logic [3:0]  pstrb,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	// host bus pins
	input  logic [15:0] busAddr,
	input  logic [3:0]  busExt,
	input  logic        sInp,
	input  logic        sOut,
	input  logic        sMemr,
	input  logic        pWrN,
	input  logic        pSync,
	input  logic        phi,
	input  logic [7:0]  dataOutBus,
	input  logic [3:0]  irqReq,
	// data path
	output logic [7:0]  dataInBus,
	output logic        dataInDriveEnN,
	output logic        dataOutLatchEnN,
	output logic [7:0]  internalData,
	// selects
	output logic        cardSelect,
	output logic        ioCycleActive,
	output logic [15:0] blockSel,
	output logic [3:0]  k1Sel,
	output logic [1:0]  k2Sel,
	output logic [2:0]  romSel,
	output logic [1:0]  ramSel,
	output logic [5:0]  ioSel,
	// bus drivers
	output logic        prdyOut,
	output logic        prdyOe,
	output logic        mWriteOut,
	output logic        mWriteOe,
	output logic [7:0]  viOut,
	output logic [7:0]  viOe
);
	sbd_pkg::busIn_t              pins;
	sbd_pkg::busIn_t              sy;
	logic [$bits(sbd_pkg::busIn_t)-1:0] syRaw;
	sbd_pkg::sel_t                decSel;
	sbd_pkg::sel_t                nxt_sel;
	sbd_pkg::sel_t                sel_ff;
	sbd_pkg::ctl_t                ctl_ff;
	sbd_pkg::map_t                map_ff;
	sbd_pkg::route_t [3:0]        irq_ff;
	sbd_pkg::stat_t               stat;
	logic [31:0]                  rdVal;
	logic [31:0]                  wrVal;
	logic                         known;
	logic                         apbWr;
	logic [31:0]                  prdata_ff;
	logic                         pready_ff;
	logic                         pslverr_ff;
	logic [1:0]                   jumpCnt_ff;
	logic                         memrPrev_ff;
	logic                         jumpDrive;
	logic [7:0]                   jumpByte;
	logic                         pSyncPrev_ff;
	logic                         phiPrev_ff;
	logic                         pSyncRise;
	logic                         phiRise;
	logic                         prdyOe_ff;
	logic                         mWriteOut_ff;
	logic                         mWriteOe_ff;
	logic                         nxt_card;
	logic                         cardSelect_ff;
	logic                         ioCycle_ff;
	logic [7:0]                   dataIn_ff;
	logic                         dataInEnN_ff;
	logic                         latchEnN_ff;
	logic [7:0]                   internal_ff;
	logic [7:0]                   nxt_viOe;
	logic [7:0]                   viOe_ff;
	logic [7:0]                   viOut_ff;
	logic                         prdyOut_ff;

	always_comb begin
		pins         = sbd_pkg::BUS_IDLE;
		pins.addr    = busAddr;
		pins.ext     = busExt;
		pins.sInp    = sInp;
		pins.sOut    = sOut;
		pins.sMemr   = sMemr;
		pins.pWrN    = pWrN;
		pins.pSync   = pSync;
		pins.phi     = phi;
		pins.dataOut = dataOutBus;
		pins.irqReq  = irqReq;
	end

	sbd_sync #(
		.WIDTH ($bits(sbd_pkg::busIn_t)),
		.INIT  (sbd_pkg::BUS_IDLE)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (pins),
		.q   (syRaw)
	);

	assign sy = sbd_pkg::busIn_t'(syRaw);

	sbd_decode u_dec (
		.sy  (sy),
		.ctl (ctl_ff),
		.map (map_ff),
		.sel (decSel)
	);

	// apb read mux and write merge
	always_comb begin
		stat            = '0;
		stat.latched    = internal_ff;
		stat.cardSel    = cardSelect_ff;
		stat.ioCycle    = ioCycle_ff;
		stat.waitActive = prdyOe_ff;
		stat.jumpCnt    = jumpCnt_ff;
		known           = 1'h1;
		case (paddr)
			sbd_pkg::REG_CTL:  rdVal = ctl_ff;
			sbd_pkg::REG_MAP:  rdVal = map_ff;
			sbd_pkg::REG_IRQ:  rdVal = {16'h0000, irq_ff};
			sbd_pkg::REG_STAT: rdVal = stat;
			default: begin
				rdVal = 32'h0000_0000;
				known = 1'h0;
			end
		endcase
		case (paddr)
			sbd_pkg::REG_CTL: wrVal = sbd_pkg::wrMerge(rdVal, pwdata,
				pstrb, sbd_pkg::CTL_WMASK);
			sbd_pkg::REG_MAP: wrVal = sbd_pkg::wrMerge(rdVal, pwdata,
				pstrb, sbd_pkg::MAP_WMASK);
			default: wrVal = sbd_pkg::wrMerge(rdVal, pwdata,
				pstrb, sbd_pkg::IRQ_WMASK);
		endcase
	end

	assign apbWr = psel && penable && pready_ff && pwrite;

	// apb handshake: answer in the first access cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_ff  <= 1'h0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'h0;
		end else begin
			pready_ff <= psel && !penable;
			if (psel && !penable) begin
				prdata_ff  <= pwrite ? 32'h0000_0000 : rdVal;
				pslverr_ff <= !known;
			end
		end
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_ff <= sbd_pkg::CTL_RESET;
			map_ff <= sbd_pkg::MAP_RESET;
			irq_ff <= sbd_pkg::IRQ_RESET[15:0];
		end else if (apbWr) begin
			case (paddr)
				sbd_pkg::REG_CTL: ctl_ff <= wrVal;
				sbd_pkg::REG_MAP: map_ff <= wrVal;
				sbd_pkg::REG_IRQ: irq_ff <= wrVal[15:0];
				default: ;
			endcase
		end
	end

	// RQ15 reset jump bytes, counted down per read
	always_comb begin
		case (jumpCnt_ff)
			2'h3:    jumpByte = sbd_pkg::JUMP_OPCODE;
			2'h2:    jumpByte = sbd_pkg::JUMP_LOW;
			default: jumpByte = map_ff.jumpPage;
		endcase
	end

	assign jumpDrive = ctl_ff.jumpEn && jumpCnt_ff != 2'h0 && sy.sMemr;

	always_ff @(posedge clk) begin
		if (rst) begin
			jumpCnt_ff  <= sbd_pkg::JUMP_LEN;
			memrPrev_ff <= 1'h0;
		end else begin
			memrPrev_ff <= sy.sMemr;
			if (!ctl_ff.jumpEn) begin
				jumpCnt_ff <= 2'h0;
			end else if (jumpCnt_ff != 2'h0 && memrPrev_ff &&
					!sy.sMemr) begin
				jumpCnt_ff <= jumpCnt_ff - 2'h1;
			end
		end
	end

	// RQ20 memory selects yield to the jump clamp
	always_comb begin
		nxt_sel = decSel;
		if (jumpDrive) begin
			nxt_sel.rom = '0;
			nxt_sel.ram = '0;
		end
		nxt_card = |{nxt_sel.rom, nxt_sel.ram, nxt_sel.io};
	end

	// selects and data strobes
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_ff        <= '0;
			cardSelect_ff <= 1'h0;
			ioCycle_ff    <= 1'h0;
			dataIn_ff     <= 8'h00;
			dataInEnN_ff  <= 1'h1;
			latchEnN_ff   <= 1'h1;
			internal_ff   <= 8'h00;
		end else begin
			sel_ff        <= nxt_sel;
			// RQ18 card select and data-in drive
			cardSelect_ff <= nxt_card;
			ioCycle_ff    <= sy.sInp || sy.sOut;
			dataInEnN_ff  <= !((nxt_card && (sy.sMemr || sy.sInp)) ||
				jumpDrive);
			dataIn_ff     <= jumpDrive ? jumpByte : 8'h00;
			// RQ19 latch on any write or output
			latchEnN_ff   <= !(!sy.pWrN || sy.sOut);
			if (!sy.pWrN || sy.sOut) begin
				internal_ff <= sy.dataOut;
			end
		end
	end

	// RQ13 one wait state: pull ready from sync until next phase edge
	assign pSyncRise = sy.pSync && !pSyncPrev_ff;
	assign phiRise   = sy.phi && !phiPrev_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			pSyncPrev_ff <= 1'h0;
			phiPrev_ff   <= 1'h0;
			prdyOe_ff    <= 1'h0;
			prdyOut_ff   <= 1'h0;
		end else begin
			pSyncPrev_ff <= sy.pSync;
			phiPrev_ff   <= sy.phi;
			if (!ctl_ff.waitEn) begin
				prdyOe_ff <= 1'h0;
			end else if (pSyncRise) begin
				prdyOe_ff <= 1'h1;
			end else if (phiRise && !sy.pSync) begin
				prdyOe_ff <= 1'h0;
			end
		end
	end

	// RQ14 write strobe from write pulse without output status
	always_ff @(posedge clk) begin
		if (rst) begin
			mWriteOut_ff <= 1'h0;
			mWriteOe_ff  <= 1'h0;
		end else begin
			mWriteOut_ff <= !sy.pWrN && !sy.sOut;
			mWriteOe_ff  <= ctl_ff.mwrEn;
		end
	end

	// RQ12 interrupt routing onto open-drain lines
	always_comb begin
		nxt_viOe = '0;
		for (int s = 0; s < sbd_pkg::IRQ_SRCS; s++) begin
			if (irq_ff[s].en && sy.irqReq[s]) begin
				nxt_viOe[irq_ff[s].line] = 1'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			viOe_ff  <= 8'h00;
			viOut_ff <= 8'h00;
		end else begin
			viOe_ff  <= nxt_viOe;
			viOut_ff <= 8'h00;
		end
	end

	assign prdata          = prdata_ff;
	assign pready          = pready_ff;
	assign pslverr         = pslverr_ff;
	assign dataInBus       = dataIn_ff;
	assign dataInDriveEnN  = dataInEnN_ff;
	assign dataOutLatchEnN = latchEnN_ff;
	assign internalData    = internal_ff;
	assign cardSelect      = cardSelect_ff;
	assign ioCycleActive   = ioCycle_ff;
	assign blockSel        = sel_ff.blk;
	assign k1Sel           = sel_ff.k1;
	assign k2Sel           = sel_ff.k2;
	assign romSel          = sel_ff.rom;
	assign ramSel          = sel_ff.ram;
	assign ioSel           = sel_ff.io;
	assign prdyOut         = prdyOut_ff;
	assign prdyOe          = prdyOe_ff;
	assign mWriteOut       = mWriteOut_ff;
	assign mWriteOe        = mWriteOe_ff;
	assign viOut           = viOut_ff;
	assign viOe            = viOe_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_blk;
		(!sy.sInp && !sy.sOut && !ctl_ff.extEn)
			|=> sel_ff.blk[$past(sy.addr[15:12])] && $onehot(sel_ff.blk);
	endproperty
	a_blk: assert property (p_blk) else $error("block select wrong"); // RQ1
	property p_k1;
		sel_ff.k1 != 4'h0 |-> sel_ff.k1 == (4'h1 << $past(sy.addr[11:10]));
	endproperty
	a_k1: assert property (p_k1) else $error("1K select wrong"); // RQ2
	property p_k2;
		sel_ff.k2 != 2'h0 |-> $onehot(sel_ff.k2) &&
			sel_ff.k2[$past(sy.addr[11])];
	endproperty
	a_k2: assert property (p_k2) else $error("2K select wrong"); // RQ3
	property p_iobase;
		sel_ff.io != 6'h00 |-> $past(sy.addr[7:4]) == $past(ctl_ff.ioBase);
	endproperty
	a_iobase: assert property (p_iobase) else $error("io base"); // RQ4
	property p_tty;
		sel_ff.io[sbd_pkg::IO_TTY] |-> $past(sy.addr[3:1]) == 3'h0;
	endproperty
	a_tty: assert property (p_tty) else $error("tty port map"); // RQ5
	property p_iobyte;
		(sy.sInp && sy.addr[7:0] == {ctl_ff.ioBase, sbd_pkg::IO_BYTE_OFS})
			|=> sel_ff.io[sbd_pkg::IO_BYTE] && cardSelect_ff;
	endproperty
	a_iobyte: assert property (p_iobyte) else $error("byte port"); // RQ6
	property p_rom1;
		sel_ff.rom[0] |-> $past(sy.addr[11]) == $past(map_ff.rom1Half);
	endproperty
	a_rom1: assert property (p_rom1) else $error("rom1 range"); // RQ7
	property p_rom2;
		sel_ff.rom[1] |-> ($past(map_ff.rom2Size) ?
			$past(sy.addr[11]) == $past(map_ff.rom2Idx[1]) :
			$past(sy.addr[11:10]) == $past(map_ff.rom2Idx));
	endproperty
	a_rom2: assert property (p_rom2) else $error("rom2 size"); // RQ8
	property p_ram;
		sel_ff.ram[1] |-> $past(sy.addr[11:10]) == $past(map_ff.ram2Idx);
	endproperty
	a_ram: assert property (p_ram) else $error("ram range"); // RQ9
	property p_bank;
		(sel_ff.blk != 16'h0000 && $past(ctl_ff.extEn)) |->
			$past(sy.ext) == {$past(ctl_ff.a19Pol), $past(ctl_ff.bankSel)};
	endproperty
	a_bank: assert property (p_bank) else $error("bank enable"); // RQ10
	property p_irq;
		(sy.irqReq[1] && irq_ff[1].en) |=> viOe_ff[$past(irq_ff[1].line)];
	endproperty
	a_irq: assert property (p_irq) else $error("irq route"); // RQ12
	property p_wait;
		(ctl_ff.waitEn && pSyncRise) |=> prdyOe_ff ##[1:5] !prdyOe_ff;
	endproperty
	a_wait: assert property (p_wait) else $error("wait missing"); // RQ13
	property p_mwr;
		(!sy.pWrN && sy.sOut) |=> !mWriteOut_ff && !latchEnN_ff;
	endproperty
	a_mwr: assert property (p_mwr) else $error("write strobe"); // RQ14
	property p_jump;
		(jumpCnt_ff == sbd_pkg::JUMP_LEN && jumpDrive) |=>
			dataIn_ff == sbd_pkg::JUMP_OPCODE && !dataInEnN_ff;
	endproperty
	a_jump: assert property (p_jump) else $error("jump opcode"); // RQ15
	property p_gap;
		sel_ff.io != 6'h00 |-> !(&$past(sy.addr[3:2]));
	endproperty
	a_gap: assert property (p_gap) else $error("io gap"); // RQ16
	property p_nomem;
		(sy.sInp || sy.sOut) |=> {sel_ff.blk, sel_ff.rom, sel_ff.ram} == '0;
	endproperty
	a_nomem: assert property (p_nomem) else $error("mem in io"); // RQ17
	property p_drive;
		!dataInEnN_ff |-> cardSelect_ff || $past(jumpDrive);
	endproperty
	a_drive: assert property (p_drive) else $error("data drive"); // RQ18
	property p_latch;
		sy.sOut |=> internal_ff == $past(sy.dataOut) && !latchEnN_ff;
	endproperty
	a_latch: assert property (p_latch) else $error("latch"); // RQ19
	property p_excl;
		$onehot0({sel_ff.rom, sel_ff.ram, sel_ff.io});
	endproperty
	a_excl: assert property (p_excl) else $error("selects overlap"); // RQ20

endmodule : sbd_board_decode

// [sbd_decode.sv]
// memory block, sub-block and i/o port decode
`timescale 1ns/1ps
module sbd_decode (
	// synchronised bus
	input  sbd_pkg::busIn_t sy,
	// configuration
	input  sbd_pkg::ctl_t   ctl,
	input  sbd_pkg::map_t   map,
	// selects
	output sbd_pkg::sel_t   sel
);
	logic ioCyc;
	logic bankOk;

	always_comb begin
		sel    = '0;
		ioCyc  = sy.sInp || sy.sOut;
		// RQ10 RQ11 bank enable
		bankOk = !ctl.extEn || (sy.ext == {ctl.a19Pol, ctl.bankSel});
		// RQ1 RQ17 4K block decode
		if (!ioCyc && bankOk) begin
			sel.blk = 16'h0001 << sy.addr[15:12];
		end
		if (sel.blk[ctl.memBlk]) begin
			// RQ2 1K decode
			sel.k1 = 4'h1 << sy.addr[11:10];
			// RQ3 2K decode
			sel.k2 = 2'h1 << sy.addr[11];
			// RQ9 RQ20 ram first
			if (map.ram2En && sel.k1[map.ram2Idx]) begin
				sel.ram[1] = 1'h1;
			end else if (map.ram1En && sel.k1[map.ram1Idx]) begin
				sel.ram[0] = 1'h1;
			// RQ7 masked rom half
			end else if (sel.k2[map.rom1Half]) begin
				sel.rom[0] = 1'h1;
			// RQ8 sockets sized 1K or 2K
			end else if (sbd_pkg::romHit(map.rom2Size, map.rom2Idx,
					sel.k1, sel.k2)) begin
				sel.rom[1] = 1'h1;
			end else if (map.rom3En && sbd_pkg::romHit(map.rom3Size,
					map.rom3Idx, sel.k1, sel.k2)) begin
				sel.rom[2] = 1'h1;
			end
		end
		// RQ4 RQ16 relocatable 12-port block
		if (ioCyc && sy.addr[7:4] == ctl.ioBase &&
				!(sy.addr[3] && sy.addr[2])) begin
			// RQ5 RQ6 port pairs
			sel.io = 6'h01 << sy.addr[3:1];
		end
	end

endmodule : sbd_decode

// [sbd_host_model.sv]
// host processor model driving the backplane pins
`timescale 1ns/1ps
module sbd_host_model (
	// clock
	input  logic        clk,
	// host pins
	output logic [15:0] busAddr,
	output logic [3:0]  busExt,
	output logic        sInp,
	output logic        sOut,
	output logic        sMemr,
	output logic        pWrN,
	output logic        pSync,
	output logic        phi,
	output logic [7:0]  dataOutBus,
	output logic [3:0]  irqReq
);
	logic [1:0] phiCnt;
	initial begin
		{busAddr, busExt, sInp, sOut, sMemr, pSync} = '0;
		{phiCnt, phi, dataOutBus, irqReq} = '0;
		pWrN = 1'h1;
	end
	// free running bus clock
	always @(posedge clk) begin
		phiCnt <= phiCnt + 2'h1;
		phi    <= phiCnt[1];
	end
	// kind: 0 mem read, 1 mem write, 2 input, 3 output
	task automatic start(input logic [15:0] a, input logic [3:0] e,
			input logic [1:0] k, input logic [7:0] d);
		@(posedge clk);
		busAddr    <= a;
		busExt     <= e;
		sMemr      <= (k == 2'h0);
		pWrN       <= !k[0];
		sInp       <= (k == 2'h2);
		sOut       <= (k == 2'h3);
		dataOutBus <= d;
		pSync      <= 1'h1;
		@(posedge clk);
		pSync <= 1'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask : start
	// end of cycle; released data lines show the inverse
	task automatic finish();
		@(posedge clk);
		{sMemr, sInp, sOut} <= 3'h0;
		pWrN       <= 1'h1;
		dataOutBus <= ~dataOutBus;
		repeat (4) @(posedge clk);
	endtask : finish
	task automatic irq(input logic [3:0] v);
		@(posedge clk);
		irqReq <= v;
		repeat (4) @(posedge clk);
		#1;
	endtask : irq
endmodule : sbd_host_model

// [sbd_pkg.sv]
// shared types, register map and constants for the card decode block
package sbd_pkg;

	// apb register byte offsets
	localparam logic [7:0] REG_CTL  = 8'h00;
	localparam logic [7:0] REG_MAP  = 8'h04;
	localparam logic [7:0] REG_IRQ  = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;

	// control word: strap replacements
	typedef struct packed {
		logic [15:0] rsvd;
		logic        jumpEn;
		logic        mwrEn;
		logic        waitEn;
		logic        a19Pol;
		logic [2:0]  bankSel;
		logic        extEn;
		logic [3:0]  ioBase;
		logic [3:0]  memBlk;
	} ctl_t;

	// memory map word: socket placement in the 4K block
	typedef struct packed {
		logic [7:0] rsvd2;
		logic [7:0] jumpPage;
		logic [1:0] rsvd1;
		logic [1:0] ram2Idx;
		logic       ram2En;
		logic [1:0] ram1Idx;
		logic       ram1En;
		logic [1:0] rom3Idx;
		logic       rom3Size;
		logic       rom3En;
		logic [1:0] rom2Idx;
		logic       rom2Size;
		logic       rom1Half;
	} map_t;

	// one interrupt route: enable and bus line
	typedef struct packed {
		logic       en;
		logic [2:0] line;
	} route_t;

	// status word
	typedef struct packed {
		logic [18:0] rsvd;
		logic [1:0]  jumpCnt;
		logic        waitActive;
		logic        ioCycle;
		logic        cardSel;
		logic [7:0]  latched;
	} stat_t;

	// host bus pins as sampled
	typedef struct packed {
		logic [3:0]  irqReq;
		logic [7:0]  dataOut;
		logic        phi;
		logic        pSync;
		logic        pWrN;
		logic        sMemr;
		logic        sOut;
		logic        sInp;
		logic [3:0]  ext;
		logic [15:0] addr;
	} busIn_t;

	// decoded selects
	typedef struct packed {
		logic [15:0] blk;
		logic [3:0]  k1;
		logic [1:0]  k2;
		logic [2:0]  rom;
		logic [1:0]  ram;
		logic [5:0]  io;
	} sel_t;

	localparam logic [31:0] CTL_RESET = 32'h0000_807F;
	localparam logic [31:0] MAP_RESET = 32'h00F0_3808;
	localparam logic [31:0] IRQ_RESET = 32'h0000_0000;
	localparam logic [31:0] CTL_WMASK = 32'h0000_FFFF;
	localparam logic [31:0] MAP_WMASK = 32'h00FF_3FFF;
	localparam logic [31:0] IRQ_WMASK = 32'h0000_FFFF;

	// port slots inside the i/o block
	localparam int IO_TTY  = 0;
	localparam int IO_VID  = 1;
	localparam int IO_CAS  = 2;
	localparam int IO_BYTE = 3;
	localparam int IO_USER = 4;
	localparam int IO_SW   = 5;
	localparam logic [3:0] IO_BYTE_OFS = 4'h6;

	localparam int IRQ_SRCS = 4;
	localparam int VI_LINES = 8;

	// reset jump: opcode, page low byte, page high byte
	localparam logic [7:0] JUMP_OPCODE = 8'hC3;
	localparam logic [7:0] JUMP_LOW    = 8'h00;
	localparam logic [1:0] JUMP_LEN    = 2'h3;

	localparam busIn_t BUS_IDLE = '{irqReq: 4'h0, dataOut: 8'h00,
		phi: 1'h0, pSync: 1'h0, pWrN: 1'h1, sMemr: 1'h0, sOut: 1'h0,
		sInp: 1'h0, ext: 4'h0, addr: 16'h0000};

	// socket hit from the 1K or the 2K decoder
	function automatic logic romHit(input logic size2k,
			input logic [1:0] idx, input logic [3:0] k1,
			input logic [1:0] k2);
		return size2k ? k2[idx[1]] : k1[idx];
	endfunction : romHit

	// byte-lane merge of an apb write
	function automatic logic [31:0] wrMerge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] strb,
			input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r & mask;
	endfunction : wrMerge

endpackage : sbd_pkg

// [sbd_sync.sv]
// two-flop synchroniser for the host bus pins
`timescale 1ns/1ps
module sbd_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	// clock and reset
	input  logic             clk,
	input  logic             rst,
	// pins in, synchronised out
	input  logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] q_ff;

	if (WIDTH < 1) begin : g_chk
		$error("sbd_sync width below one");
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= INIT;
			q_ff    <= INIT;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;

endmodule : sbd_sync

// [test_s100_board_address_decode.sv]
// self-checking bench for the card decode block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checksDone++; if ((e) !== (s)) begin \
	$display("BAD %s exp %0h got %0h", n, e, s); fails++; end end
module test_s100_board_address_decode;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata, q;
	logic        pready, pslverr, e;
	logic [15:0] busAddr, blockSel, a;
	logic [3:0]  busExt, irqReq, k1Sel;
	logic        sInp, sOut, sMemr, pWrN, pSync, phi;
	logic [7:0]  dataOutBus, dataInBus, internalData, viOut, viOe;
	logic        dataInDriveEnN, dataOutLatchEnN, cardSelect;
	logic        ioCycleActive, prdyOut, prdyOe, mWriteOut, mWriteOe;
	logic [1:0]  k2Sel, ramSel;
	logic [2:0]  romSel;
	logic [5:0]  ioSel, xIo;
	logic [7:0]  jb [3];
	int          fails = 0, checksDone = 0, waitCnt = 0;

	sbd_board_decode u_dut (.clk, .rst, .paddr, .psel, .penable, .pwrite,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .busAddr, .busExt,
		.sInp, .sOut, .sMemr, .pWrN, .pSync, .phi, .dataOutBus, .irqReq,
		.dataInBus, .dataInDriveEnN, .dataOutLatchEnN, .internalData,
		.cardSelect, .ioCycleActive, .blockSel, .k1Sel, .k2Sel, .romSel,
		.ramSel, .ioSel, .prdyOut, .prdyOe, .mWriteOut, .mWriteOe,
		.viOut, .viOe);
	sbd_host_model u_host (.clk, .busAddr, .busExt, .sInp, .sOut, .sMemr,
		.pWrN, .pSync, .phi, .dataOutBus, .irqReq);

	always #50 clk = ~clk;
	// cycles with the wait pull active
	always @(posedge clk) if (prdyOe === 1'h1) waitCnt <= waitCnt + 1;

	task automatic testDone();
		if (fails == 0 && checksDone > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : testDone

	task automatic apb(input logic [7:0] ad, input logic w,
			input logic [31:0] d, output logic [31:0] r, output logic x);
		int n;
		n = 0;
		@(posedge clk);
		paddr  <= ad;
		pwrite <= w;
		pwdata <= d;
		psel   <= 1'h1;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) fails++;
		r = prdata;
		x = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] r;
		logic        x;
		apb(ad, 1'h1, d, r, x);
	endtask : wr

	task automatic rdChk(input logic [7:0] ad, input logic [31:0] v);
		logic [31:0] r;
		logic        x;
		apb(ad, 1'h0, 32'h0000_0000, r, x);
		`CHK("reg", v, r)
	endtask : rdChk

	initial begin
		#(100 * 8000);
		fails++;
		testDone();
	end

	initial begin
		jb = '{sbd_pkg::JUMP_OPCODE, sbd_pkg::JUMP_LOW,
			sbd_pkg::MAP_RESET[23:16]};
		repeat (2) @(posedge clk);
		#1;
		`CHK("romReset", 5'h00, {romSel, ramSel})
		@(posedge clk);
		rst <= 1'h0;
		rdChk(sbd_pkg::REG_CTL, sbd_pkg::CTL_RESET);
		rdChk(sbd_pkg::REG_MAP, sbd_pkg::MAP_RESET);
		rdChk(sbd_pkg::REG_IRQ, sbd_pkg::IRQ_RESET);
		apb(8'h10, 1'h0, 32'h0000_0000, q, e);
		`CHK("slverr", 1'h1, e)
		for (int i = 0; i < 3; i++) begin
			u_host.start(16'hF000, 4'h0, 2'h0, 8'h00);
			`CHK("jumpByte", jb[i], dataInBus)
			`CHK("jumpDrive", 1'h0, dataInDriveEnN)
			`CHK("jumpRom", 3'h0, romSel)
			u_host.finish();
		end
		for (int i = 0; i < 20; i++) begin
			a = i < 16 ? {i[3:0], 12'h000} : {4'hF, i[1:0], 10'h000};
			u_host.start(a, 4'h0, 2'h0, 8'h00);
			`CHK("blockSel", 16'h1 << a[15:12], blockSel)
			`CHK("drive", a[15:12] != 4'hF, dataInDriveEnN)
			if (i >= 16) begin
				`CHK("k1Sel", 4'h1 << a[11:10], k1Sel)
				`CHK("k2Sel", 2'h1 << a[11], k2Sel)
				`CHK("rom", {1'h0, a[11:10] == 2'h2, !a[11]}, romSel)
				`CHK("ram", {a[11:10] == 2'h3, 1'h0}, ramSel)
			end
			u_host.finish();
		end
		wr(sbd_pkg::REG_CTL, sbd_pkg::CTL_RESET | 32'h0000_4000);
		u_host.start(16'hFC10, 4'h0, 2'h1, 8'h5A);
		`CHK("latch", 8'h5A, internalData)
		`CHK("latchEn", 1'h0, dataOutLatchEnN)
		`CHK("mWrite", 2'h3, {mWriteOut, mWriteOe})
		`CHK("drive", 1'h1, dataInDriveEnN)
		u_host.finish();
		u_host.start(16'h0071, 4'h0, 2'h3, 8'hA5);
		`CHK("latchOut", 8'hA5, internalData)
		`CHK("mWriteOut", 1'h0, mWriteOut)
		u_host.finish();
		for (int o = 0; o < 16; o++) begin
			u_host.start(16'h0070 | o[15:0], 4'h0, 2'h2, 8'h00);
			xIo = o[3:2] == 2'h3 ? 6'h00 : 6'h01 << o[3:1];
			`CHK("ioSel", xIo, ioSel)
			`CHK("card", xIo != 6'h00, cardSelect)
			`CHK("ioCycle", 1'h1, ioCycleActive)
			`CHK("memOff", 16'h0000, blockSel)
			u_host.finish();
		end
		wr(sbd_pkg::REG_CTL, 32'h0000_803F);
		for (int i = 0; i < 2; i++) begin
			u_host.start(i ? 16'h0070 : 16'h0030, 4'h0, 2'h2, 8'h00);
			`CHK("ioMoved", i ? 6'h00 : 6'h01, ioSel)
			u_host.finish();
		end
		for (int i = 0; i < 2; i++) begin
			wr(sbd_pkg::REG_MAP, i ? 32'h00F0_30D8 : 32'h00F0_380A);
			u_host.start(i ? 16'hFC00 : 16'hF800, 4'h0, 2'h0, 8'h00);
			`CHK("romSocket", i ? 3'h4 : 3'h2, romSel)
			u_host.finish();
		end
		wr(sbd_pkg::REG_CTL, 32'h0000_957F);
		for (int i = 0; i < 2; i++) begin
			u_host.start(16'hF000, i ? 4'h2 : 4'hA, 2'h0, 8'h00);
			`CHK("bank", i ? 16'h0000 : 16'h8000, blockSel)
			u_host.finish();
		end
		wr(sbd_pkg::REG_IRQ, 32'h0000_00D0);
		u_host.irq(4'h2);
		`CHK("viOe", 8'h20, viOe)
		u_host.irq(4'h1);
		`CHK("viOff", 8'h00, viOe)
		`CHK("noWait", 0, waitCnt)
		wr(sbd_pkg::REG_CTL, 32'h0000_A07F);
		u_host.start(16'h0000, 4'h0, 2'h0, 8'h00);
		u_host.finish();
		`CHK("oneWait", 1'h1, waitCnt inside {[1:6]})
		testDone();
	end
endmodule : test_s100_board_address_decode
